// >>> pkg/clk_mode_pkg.sv
// Constants and types shared by the clock and operating-mode controller
package clk_mode_pkg;
    // Register byte offsets
    localparam logic [7:0] SYSCLK_CTRL_OFFSET = 8'h00;
    localparam logic [7:0] FAST_OSC_CTRL_OFFSET = 8'h04;
    localparam logic [7:0] MODE_STATUS_OFFSET = 8'h08;
    // Field positions
    localparam int SEL_LSB = 5;
    localparam int FAST_KEEP_BIT = 1;
    localparam int SLOW_KEEP_BIT = 0;
    localparam int FREQ_LSB = 2;
    localparam int STABLE_BIT = 1;
    localparam int FAST_EN_BIT = 0;
    // Reset values
    localparam logic [7:0] SYSCLK_CTRL_RESET = 8'h40;
    localparam logic [7:0] FAST_OSC_CTRL_RESET = 8'h01;
    // Encodings
    localparam logic [2:0] SEL_SUB_CLOCK = 3'h7;
    localparam logic [1:0] FREQ_16MHZ = 2'h1;
    localparam logic [1:0] FREQ_20MHZ = 2'h2;
    // Timing
    localparam int CLK_HZ = 20_000_000;
    localparam int CLK_PERIOD_NS = 50;
    localparam int SLOW_OSC_HZ = 32_000;
    localparam int SLOW_DIV_CYCLES = CLK_HZ / SLOW_OSC_HZ;
    localparam int FAST_SETTLE_NS = 1000;
    localparam int FAST_SETTLE_CYCLES = (FAST_SETTLE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int FAST16_PATTERN_LEN = 5;
    localparam int FAST_DIV_WIDTH = 6;

    typedef enum logic [2:0] {
        MODE_FAST = 3'b000,
        MODE_SLOW = 3'b001,
        MODE_SLEEP = 3'b010,
        MODE_IDLE_SUB_ONLY = 3'b011,
        MODE_IDLE_BOTH_OSC = 3'b100,
        MODE_IDLE_FAST_ONLY = 3'b101
    } mode_t;
endpackage

// >>> tb/tb_top.sv
// Self-checking testbench for the clock and operating-mode controller
`timescale 1ns/10ps
`default_nettype none
module tb_top;
import clk_mode_pkg::*;
localparam int WATCHDOG_CYCLES = 60000;
typedef struct packed {
    logic [2:0] sel;
    logic [1:0] keeps;
    logic fen;
    logic wd;
    logic halt;
    logic [2:0] exp_mode;
    logic [3:0] exp_on;
} row_t;
logic pclk = 1'b0;
logic presetn = 1'b0;
logic [7:0] paddr = 8'h00;
logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
logic [31:0] pwdata = 32'h0, prdata;
logic pready, pslverr;
logic halt_req = 1'b0, wake_req = 1'b0, watchdog_enable = 1'b0;
logic cpu_run, system_clock_en, fast_clock_en, sub_clock_en;
logic slow_osc_clock_en, watchdog_clock_en, timebase_clock_en;
mode_t mode;
int miscompares = 0;
int comparisons = 0;
int n_sys, n_fast, n_sub, n_slow, n_wd, n_tb, min_gap;
int n_f16;
logic fast16_en;
logic [2:0] exp_m;
logic [31:0] rd;
logic er;
// Enables are {system, fast, sub, slow}
row_t rows [11] = '{
    '{3'h0, 2'h0, 1'b1, 1'b0, 1'b0, 3'h0, 4'hF}, '{3'h7, 2'h0, 1'b1, 1'b0, 1'b0, 3'h1, 4'hF},
    '{3'h7, 2'h0, 1'b0, 1'b0, 1'b0, 3'h1, 4'hB}, '{3'h0, 2'h0, 1'b1, 1'b0, 1'b1, 3'h2, 4'h0},
    '{3'h0, 2'h0, 1'b1, 1'b1, 1'b1, 3'h2, 4'h1}, '{3'h0, 2'h1, 1'b1, 1'b0, 1'b1, 3'h3, 4'h3},
    '{3'h7, 2'h1, 1'b1, 1'b0, 1'b1, 3'h3, 4'hB}, '{3'h0, 2'h3, 1'b1, 1'b0, 1'b1, 3'h4, 4'hF},
    '{3'h7, 2'h3, 1'b1, 1'b0, 1'b1, 3'h4, 4'hF}, '{3'h0, 2'h2, 1'b1, 1'b0, 1'b1, 3'h5, 4'hD},
    '{3'h7, 2'h2, 1'b1, 1'b0, 1'b1, 3'h5, 4'h5}};

system_clock_mode_control #(.FAST_CFG_20MHZ(1'b1)) dut (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .halt_req(halt_req), .wake_req(wake_req), .watchdog_enable(watchdog_enable),
    .cpu_run(cpu_run), .system_clock_en(system_clock_en), .fast_clock_en(fast_clock_en),
    .sub_clock_en(sub_clock_en), .slow_osc_clock_en(slow_osc_clock_en),
    .watchdog_clock_en(watchdog_clock_en), .timebase_clock_en(timebase_clock_en), .mode(mode));

// Second copy built for the 16 MHz option; only its fast rate is watched
system_clock_mode_control #(.FAST_CFG_20MHZ(1'b0)) dut16 (
    .pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
    .pwrite(pwrite), .pwdata(pwdata), .prdata(), .pready(), .pslverr(),
    .halt_req(halt_req), .wake_req(wake_req), .watchdog_enable(watchdog_enable),
    .cpu_run(), .system_clock_en(), .fast_clock_en(fast16_en), .sub_clock_en(),
    .slow_osc_clock_en(), .watchdog_clock_en(), .timebase_clock_en(), .mode());

always #25 pclk = ~pclk;

// Mode a halt leads to from a run mode, by the two keep-alive bits
function automatic logic [2:0] halt_mode(input logic [1:0] keeps);
    case (keeps)
        2'b00: return MODE_SLEEP;
        2'b01: return MODE_IDLE_SUB_ONLY;
        2'b11: return MODE_IDLE_BOTH_OSC;
        default: return MODE_IDLE_FAST_ONLY;
    endcase
endfunction

// --------------------------------------------------------------
// Bus, pulse and compare helpers
// --------------------------------------------------------------
task automatic chk_val(input logic [31:0] got, input logic [31:0] exp, input string what);
    comparisons++;
    if (got !== exp) begin
        miscompares++;
        $display("BAD %0t %s got %h want %h", $time, what, got, exp);
    end
endtask
task automatic chk_cnt(input int got, input int lo, input int hi, input string what);
    comparisons++;
    if (got < lo || got > hi) begin
        miscompares++;
        $display("BAD %0t %s count %0d", $time, what, got);
    end
endtask
task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int k;
    k = 0;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    // Ready is judged at the rising edge; data and error are taken at that edge
    do begin
        @(posedge pclk);
        k++;
    end while (pready !== 1'b1 && k < 50);
    chk_val({31'h0, pready}, 32'h1, "pready");
    rd = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
endtask
task automatic pulse(input bit halt);
    @(posedge pclk);
    if (halt) halt_req <= 1'b1; else wake_req <= 1'b1;
    @(posedge pclk);
    halt_req <= 1'b0; wake_req <= 1'b0;
endtask
task automatic measure(input int n);
    int last;
    n_sys = 0; n_fast = 0; n_sub = 0; n_slow = 0; n_wd = 0; n_tb = 0;
    n_f16 = 0;
    min_gap = 1000; last = -1000;
    for (int i = 0; i < n; i++) begin
        @(negedge pclk);
        if (system_clock_en === 1'b1) begin
            if (i - last < min_gap) min_gap = i - last;
            last = i;
            n_sys++;
        end
        n_fast += (fast_clock_en === 1'b1); n_sub += (sub_clock_en === 1'b1);
        n_slow += (slow_osc_clock_en === 1'b1); n_wd += (watchdog_clock_en === 1'b1);
        n_tb += (timebase_clock_en === 1'b1);
        n_f16 += (fast16_en === 1'b1);
    end
endtask
task automatic wrap_up;
    if (miscompares == 0 && comparisons > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
endtask

initial begin
    repeat (WATCHDOG_CYCLES) @(posedge pclk);
    miscompares++;
    wrap_up();
end

// --------------------------------------------------------------
// Main sequence
// --------------------------------------------------------------
initial begin
    repeat (10) @(posedge pclk);
    chk_val({28'h0, cpu_run, mode}, 32'h8, "reset outputs");
    presetn <= 1'b1;
    foreach (rows[i]) begin
        pulse(1'b0);
        watchdog_enable <= rows[i].wd;
        apb(1'b1, FAST_OSC_CTRL_OFFSET, {28'h0, FREQ_20MHZ, 1'b0, rows[i].fen});
        apb(1'b1, SYSCLK_CTRL_OFFSET, {24'h0, rows[i].sel, 3'h0, rows[i].keeps});
        repeat (700) @(posedge pclk);
        if (rows[i].halt) pulse(1'b1);
        repeat (5) @(posedge pclk);
        chk_val({28'h0, cpu_run, mode}, {28'h0, ~rows[i].halt, rows[i].exp_mode}, "mode");
        measure(1400);
        chk_val({28'h0, n_sys > 0, n_fast > 0, n_sub > 0, n_slow > 0}, {28'h0, rows[i].exp_on},
            "clocks");
        chk_val({30'h0, n_wd > 0, n_tb > 0}, {30'h0, n_slow > 0, n_fast + n_slow > 0}, "wd tb");
        pulse(1'b1);
        repeat (3) @(posedge pclk);
        // A halt in a run row enters a halt mode; in a halted row it is ignored
        exp_m = rows[i].halt ? rows[i].exp_mode : halt_mode(rows[i].keeps);
        chk_val({29'h0, mode}, {29'h0, exp_m}, "repeat halt");
    end
    // Divide ratios in FAST mode, no pulse closer than the ratio
    pulse(1'b0);
    for (int k = 0; k < 7; k++) begin
        apb(1'b1, SYSCLK_CTRL_OFFSET, {24'h0, k[2:0], 5'h0});
        // Leaving the sub source waits for its next tick, up to one slow period
        repeat (700) @(posedge pclk);
        measure(640);
        chk_cnt(n_sys, (640 >> k) - 1, (640 >> k) + 1, "divider");
        chk_cnt(min_gap, 1 << k, 1000, "gap");
        chk_cnt(n_fast, 640, 640, "fast rate");
        chk_cnt(n_f16, 512, 512, "fast rate 16");
    end
    // Register access, read-only bits, unmapped place
    apb(1'b1, SYSCLK_CTRL_OFFSET, 32'hFFFFFFFF);
    apb(1'b0, SYSCLK_CTRL_OFFSET, 32'h0);
    chk_val(rd, 32'hE3, "sysclk ctrl");
    apb(1'b1, FAST_OSC_CTRL_OFFSET, 32'h8);
    apb(1'b1, FAST_OSC_CTRL_OFFSET, 32'hB);
    apb(1'b0, FAST_OSC_CTRL_OFFSET, 32'h0);
    chk_val(rd, 32'h9, "stable cleared");
    repeat (30) @(posedge pclk);
    apb(1'b0, FAST_OSC_CTRL_OFFSET, 32'h0);
    chk_val(rd, 32'hB, "stable set");
    apb(1'b1, MODE_STATUS_OFFSET, 32'h5);
    apb(1'b0, MODE_STATUS_OFFSET, 32'h0);
    chk_val(rd, 32'h1, "status ro");
    apb(1'b1, 8'h0C, 32'hFF);
    chk_val({31'h0, er}, 32'h1, "unmapped write");
    apb(1'b0, 8'h0C, 32'h0);
    chk_val({er, rd[30:0]}, 32'h80000000, "unmapped read");
    // Second reset in mid-run
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (3) @(posedge pclk);
    chk_val({28'h0, cpu_run, mode}, 32'h8, "mid reset");
    presetn <= 1'b1;
    apb(1'b0, SYSCLK_CTRL_OFFSET, 32'h0);
    chk_val(rd, {24'h0, SYSCLK_CTRL_RESET}, "sysclk reset");
    apb(1'b0, FAST_OSC_CTRL_OFFSET, 32'h0);
    chk_val(rd, {24'h0, FAST_OSC_CTRL_RESET}, "fast ctrl reset");
    wrap_up();
end
endmodule // tb_top
`default_nettype wire

// >>> verilog/sysclk_gen.sv
// System clock enable generator with boundary-aligned source switching
`timescale 1ns/10ps
`default_nettype none
module sysclk_gen (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // Source ticks
    input wire logic fast_tick,
    input wire logic sub_tick,
    // Control
    input wire logic [2:0] select,
    input wire logic gate,
    // Result
    output logic sysclk_pulse
);
    import clk_mode_pkg::*;

    logic [FAST_DIV_WIDTH-1:0] div_cnt;
    logic [2:0] active_sel;

    function automatic logic div_hit(input logic [FAST_DIV_WIDTH-1:0] cnt,
                                     input logic [2:0] sel);
        logic [FAST_DIV_WIDTH-1:0] mask;
        mask = ~({FAST_DIV_WIDTH{1'b1}} << sel);
        return (cnt & mask) == mask;
    endfunction

    wire logic on_sub = (active_sel == SEL_SUB_CLOCK);
    wire logic src_pulse = on_sub ? sub_tick : (fast_tick && div_hit(div_cnt, active_sel));
    // A new source or ratio is taken only at the end of a whole period
    wire logic take_new = src_pulse && (select != active_sel);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            div_cnt <= '0;
            active_sel <= SYSCLK_CTRL_RESET[SEL_LSB +: 3];
            sysclk_pulse <= 1'b0;
        end else begin
            if (take_new) begin
                div_cnt <= '0;
                active_sel <= select;
            end else if (fast_tick) begin
                div_cnt <= div_cnt + 1'b1;
            end
            sysclk_pulse <= src_pulse && gate;
        end
    end

    // Only a pulse that came from the sub source and kept it is checked, since
    // the hand-over pulse from the fast source may sit next to a sub pulse
    a_no_short_sub: assert property (@(posedge pclk) disable iff (!presetn)
        (sysclk_pulse && on_sub && $past(on_sub)) |=> !sysclk_pulse [*8])
        else $error("system clock pulse shortened on the sub-clock");
endmodule // sysclk_gen
`default_nettype wire

// >>> verilog/system_clock_mode_control.sv
// System clock selection and operating-mode control with APB registers
//
// Functional notes
// - Fast clock from internal RC at 16 or 20 MHz, fixed by configuration.
// - Sub-clock comes from a slow internal RC oscillator near 32 kHz.
// - Select codes 000 to 110: FAST mode, fast clock divided 1 to 64.
// - Select code 111: SLOW mode, system clock from the sub-clock.
// - FAST and SLOW run CPU, sub and slow clocks; FAST keeps fast clock.
// - In SLOW the fast oscillator runs or stops per its enable bit.
// - Oscillators also clock the watchdog and the time base unit.
// - Halt with both keep bits 0 enters SLEEP; all clocks but slow stop.
// - In SLEEP slow oscillator runs only when the watchdog is enabled.
// - Halt, fast keep 0, slow keep 1: sub-only idle, sysclk only if 111.
// - Halt, both keep bits 1: both-osc idle, system clock always runs.
// - Halt, fast keep 1, slow keep 0: fast-only idle, sysclk only if not 111.
// - Enabling the fast oscillator clears stable flag until it settles.
`timescale 1ns/10ps
`default_nettype none
module system_clock_mode_control #(
    parameter bit FAST_CFG_20MHZ = 1'b1
) (
    // Clock and reset
    input wire logic pclk,
    input wire logic presetn,
    // APB slave
    input wire logic [7:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // CPU and watchdog side
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic watchdog_enable,
    // Clock enables and status
    output logic cpu_run,
    output logic system_clock_en,
    output logic fast_clock_en,
    output logic sub_clock_en,
    output logic slow_osc_clock_en,
    output logic watchdog_clock_en,
    output logic timebase_clock_en,
    output clk_mode_pkg::mode_t mode
);
    import clk_mode_pkg::*;

    // ------------------------------------------------------------
    // Registers and state
    // ------------------------------------------------------------
    logic [2:0] sysclk_select;
    logic fast_osc_idle_keep;
    logic slow_osc_idle_keep;
    logic [1:0] fast_osc_freq_select;
    logic fast_osc_enable;
    logic fast_osc_stable_flag;
    logic [7:0] settle_cnt;
    logic fast_on_q;
    logic [2:0] fast_phase;
    logic [9:0] slow_cnt;
    mode_t next_mode;
    logic sys_pulse;

    // ------------------------------------------------------------
    // APB decode
    // ------------------------------------------------------------
    wire logic setup_phase = psel && !penable;
    wire logic access_done = psel && penable && pready;
    wire logic hit_sysclk = (paddr == SYSCLK_CTRL_OFFSET);
    wire logic hit_fast = (paddr == FAST_OSC_CTRL_OFFSET);
    wire logic hit_mode = (paddr == MODE_STATUS_OFFSET);
    wire logic hit_any = hit_sysclk || hit_fast || hit_mode;
    wire logic wr_sysclk = access_done && pwrite && hit_sysclk;
    wire logic wr_fast = access_done && pwrite && hit_fast;

    wire logic [7:0] sysclk_view = {sysclk_select, 3'h0, fast_osc_idle_keep,
                                    slow_osc_idle_keep};
    wire logic [7:0] fast_view = {4'h0, fast_osc_freq_select, fast_osc_stable_flag,
                                  fast_osc_enable};
    wire logic [31:0] read_mux = hit_sysclk ? {24'h0, sysclk_view} :
                                 hit_fast ? {24'h0, fast_view} :
                                 hit_mode ? {29'h0, mode} : 32'h0;

    // ------------------------------------------------------------
    // Oscillator control
    // ------------------------------------------------------------
    wire logic in_run = (mode == MODE_FAST) || (mode == MODE_SLOW);
    // The fast oscillator always runs in FAST; in SLOW its enable decides
    wire logic fast_osc_on = (mode == MODE_FAST)
                             || (mode == MODE_SLOW && fast_osc_enable)
                             || (mode == MODE_IDLE_BOTH_OSC)
                             || (mode == MODE_IDLE_FAST_ONLY);
    // Changing frequency or re-enabling restarts the settle wait
    wire logic freq_change = wr_fast && (pwdata[FREQ_LSB +: 2] != fast_osc_freq_select);
    wire logic en_rise = wr_fast && pwdata[FAST_EN_BIT] && !fast_osc_enable;
    wire logic settle_restart = (fast_osc_on && !fast_on_q) || freq_change || en_rise;
    // 16 MHz from a 20 MHz clock: four ticks in every five cycles
    wire logic fast_tick = fast_osc_on && fast_osc_stable_flag
                           && (FAST_CFG_20MHZ || fast_phase != 3'(FAST16_PATTERN_LEN - 1));
    // Slow oscillator stops in SLEEP unless the watchdog needs it
    wire logic slow_osc_on = !(mode == MODE_SLEEP && !watchdog_enable);
    wire logic slow_tick = slow_osc_on && (slow_cnt == 10'h000);
    wire logic sub_on = in_run || (mode == MODE_IDLE_SUB_ONLY)
                        || (mode == MODE_IDLE_BOTH_OSC);
    wire logic sub_tick = slow_tick && sub_on;
    wire logic sel_sub = (sysclk_select == SEL_SUB_CLOCK);
    wire logic sys_gate = in_run || (mode == MODE_IDLE_BOTH_OSC)
                          || (mode == MODE_IDLE_SUB_ONLY && sel_sub)
                          || (mode == MODE_IDLE_FAST_ONLY && !sel_sub);

    // ------------------------------------------------------------
    // Mode sequencing
    // ------------------------------------------------------------
    wire mode_t run_mode = sel_sub ? MODE_SLOW : MODE_FAST;
    wire logic [1:0] keep_bits = {fast_osc_idle_keep, slow_osc_idle_keep};

    always_comb begin
        next_mode = mode;
        case (mode)
            MODE_FAST, MODE_SLOW: begin
                if (halt_req) begin
                    case (keep_bits)
                        2'b00: next_mode = MODE_SLEEP;
                        2'b01: next_mode = MODE_IDLE_SUB_ONLY;
                        2'b11: next_mode = MODE_IDLE_BOTH_OSC;
                        default: next_mode = MODE_IDLE_FAST_ONLY;
                    endcase
                end else begin
                    next_mode = run_mode;
                end
            end
            MODE_SLEEP, MODE_IDLE_SUB_ONLY, MODE_IDLE_BOTH_OSC, MODE_IDLE_FAST_ONLY: begin
                if (wake_req) begin
                    next_mode = run_mode;
                end
            end
            default: next_mode = run_mode;
        endcase
    end

    // ------------------------------------------------------------
    // System clock generator
    // ------------------------------------------------------------
    sysclk_gen u_sysclk_gen (
        .pclk(pclk),
        .presetn(presetn),
        .fast_tick(fast_tick),
        .sub_tick(sub_tick),
        .select(sysclk_select),
        .gate(sys_gate),
        .sysclk_pulse(sys_pulse)
    );

    // ------------------------------------------------------------
    // Sequential logic
    // ------------------------------------------------------------
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0;
        end else begin
            // One access cycle: ready is raised for the cycle after setup
            pready <= setup_phase;
            pslverr <= setup_phase && !hit_any;
            if (setup_phase) begin
                prdata <= read_mux;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sysclk_select <= SYSCLK_CTRL_RESET[SEL_LSB +: 3];
            fast_osc_idle_keep <= SYSCLK_CTRL_RESET[FAST_KEEP_BIT];
            slow_osc_idle_keep <= SYSCLK_CTRL_RESET[SLOW_KEEP_BIT];
            fast_osc_freq_select <= FAST_OSC_CTRL_RESET[FREQ_LSB +: 2];
            fast_osc_enable <= FAST_OSC_CTRL_RESET[FAST_EN_BIT];
        end else begin
            if (wr_sysclk) begin
                sysclk_select <= pwdata[SEL_LSB +: 3];
                fast_osc_idle_keep <= pwdata[FAST_KEEP_BIT];
                slow_osc_idle_keep <= pwdata[SLOW_KEEP_BIT];
            end
            // Frequency select is stored as written; matching it to the
            // configuration option is software's duty
            if (wr_fast) begin
                fast_osc_freq_select <= pwdata[FREQ_LSB +: 2];
                fast_osc_enable <= pwdata[FAST_EN_BIT];
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            fast_on_q <= 1'b0;
            settle_cnt <= 8'h00;
            fast_osc_stable_flag <= 1'b0;
            fast_phase <= 3'h0;
            slow_cnt <= 10'h000;
        end else begin
            fast_on_q <= fast_osc_on;
            if (!fast_osc_on || settle_restart) begin
                fast_osc_stable_flag <= 1'b0;
                settle_cnt <= 8'(FAST_SETTLE_CYCLES);
            end else if (settle_cnt != 8'h00) begin
                settle_cnt <= settle_cnt - 8'h01;
                fast_osc_stable_flag <= (settle_cnt == 8'h01);
            end
            if (fast_phase == 3'(FAST16_PATTERN_LEN - 1)) begin
                fast_phase <= 3'h0;
            end else begin
                fast_phase <= fast_phase + 3'h1;
            end
            if (!slow_osc_on || slow_cnt == 10'(SLOW_DIV_CYCLES - 1)) begin
                slow_cnt <= 10'h000;
            end else begin
                slow_cnt <= slow_cnt + 10'h001;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            mode <= MODE_FAST;
            cpu_run <= 1'b1;
            system_clock_en <= 1'b0;
            fast_clock_en <= 1'b0;
            sub_clock_en <= 1'b0;
            slow_osc_clock_en <= 1'b0;
            watchdog_clock_en <= 1'b0;
            timebase_clock_en <= 1'b0;
        end else begin
            mode <= next_mode;
            cpu_run <= (next_mode == MODE_FAST) || (next_mode == MODE_SLOW);
            system_clock_en <= sys_pulse;
            fast_clock_en <= fast_tick;
            sub_clock_en <= sub_tick;
            slow_osc_clock_en <= slow_tick;
            watchdog_clock_en <= slow_tick;
            timebase_clock_en <= fast_osc_on ? fast_tick : slow_tick;
        end
    end

    // ------------------------------------------------------------
    // Assertions
    // ------------------------------------------------------------
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    // The system enable lags the internal tick by two cycles, one more than the others
    a_sleep_entry: assert property ((in_run && halt_req && keep_bits == 2'b00) |=>
        (mode == MODE_SLEEP) ##1 (!cpu_run && !fast_clock_en) ##1 !system_clock_en)
        else $error("halt with keep bits 00 did not stop clocks");
    a_idle_sub_entry: assert property ((in_run && halt_req && keep_bits == 2'b01) |=>
        mode == MODE_IDLE_SUB_ONLY)
        else $error("halt with keep bits 01 did not enter sub-only idle");
    a_idle_both_sys: assert property ($rose(mode == MODE_IDLE_BOTH_OSC)
        |-> ##[1:700] system_clock_en)
        else $error("system clock gated in both-osc idle");
    a_idle_fast_sub: assert property ((mode == MODE_IDLE_FAST_ONLY) |=> !sub_clock_en)
        else $error("sub clock ran in fast-only idle");
    a_sleep_wdt_off: assert property ((mode == MODE_SLEEP && !watchdog_enable)
        |=> !slow_osc_clock_en)
        else $error("slow oscillator ran in sleep with watchdog off");
    a_fast_mode_on: assert property ((mode == MODE_FAST) |-> fast_osc_on && sub_on)
        else $error("fast mode lost an oscillator");
    a_slow_fast_off: assert property ((mode == MODE_SLOW && !fast_osc_enable)
        |=> !fast_clock_en)
        else $error("fast clock ran in slow mode while disabled");
    a_stable_clear: assert property ($rose(fast_osc_on) |-> ##1
        (!fast_osc_stable_flag [*8]))
        else $error("stable flag not held low after oscillator start");
    a_slow_period: assert property ($rose(slow_osc_clock_en) |=>
        !slow_osc_clock_en [*8])
        else $error("slow clock pulses too close together");
endmodule // system_clock_mode_control
`default_nettype wire
